/* File: inverter_fault_shutdown_logic.sv */
// Fault management and smart shutdown for a three-phase gate driver
// What this block does
// - Any fault turns on the shutdown-line pull-down and forces all low-side gates low within five clock edges.
// - Only two faults exist: overcurrent from the sense comparator and supply undervoltage.
// - An overcurrent holds the pull-down for 20 us, or for the whole event if longer.
// - An undervoltage holds the pull-down at least 50 us unless an overcurrent takes over, and longer until the supply recovers.
// - Gates stay off whenever the shutdown line reads low, so outside hold time adds on.
// - A comparator trip enters shutdown and drives every gate output low.
// - The comparator trip turns gates off by a direct path, not through the shutdown line.
// - After overcurrent the pull-down stays on until the line is below unlatch level and time is up.
// - Once the line reads high again the gates follow the phase commands.
// - Phase commands are active high; a high level turns the matching gate on.
// - The unlatch level is a separate qualifier input meaning the line is below about 0.6 V.
`timescale 1ns/1ns
module inverter_fault_shutdown_logic
    import fault_pkg::*;
#(
    parameter int unsigned OC_CYCLES = OC_HOLD_CYC,
    parameter int unsigned UV_CYCLES = UV_HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic faultClear,
    input wire logic [PHASES-1:0] highSideCommand,
    input wire logic [PHASES-1:0] lowSideCommand,
    input wire logic currentSenseInput,
    input wire logic undervoltageLockout,
    input wire logic sharedShutdownLineIn,
    input wire logic unlatchQualifier,
    output logic sharedShutdownLineOut,
    output logic sharedShutdownLineOe,
    output logic [PHASES-1:0] highSideGate,
    output logic [PHASES-1:0] lowSideGateOutputs,
    output logic faultActive
);
    localparam logic [HOLD_W-1:0] OC_LOAD = HOLD_W'(OC_CYCLES - 1);
    localparam logic [HOLD_W-1:0] UV_LOAD = HOLD_W'(UV_CYCLES - 1);

    logic [PHASES-1:0] highCmdSync;
    logic [PHASES-1:0] lowCmdSync;
    logic overcurrentFault;
    logic uvSync;
    logic lineSync;
    logic unlatchSync;

    fault_state_e state_q;
    fault_state_e state_d;
    logic [HOLD_W-1:0] holdCnt_q;
    logic [HOLD_W-1:0] holdCnt_d;
    logic pullOe_q;
    logic pullOe_d;
    logic [PHASES-1:0] highGate_q;
    logic [PHASES-1:0] highGate_d;
    logic [PHASES-1:0] lowGate_q;
    logic [PHASES-1:0] lowGate_d;

    // Synchronise all pins but faultClear; the line resets high since it idles on its pull-up
    pin_sync #(.WIDTH(2 * PHASES), .RESET_VAL('0)) u_cmd_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din({highSideCommand, lowSideCommand}),
        .dout({highCmdSync, lowCmdSync})
    );
    pin_sync #(.WIDTH(3), .RESET_VAL({IN_RESET, IN_RESET, IN_RESET})) u_fault_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din({currentSenseInput, undervoltageLockout, unlatchQualifier}),
        .dout({overcurrentFault, uvSync, unlatchSync})
    );
    pin_sync #(.WIDTH(1), .RESET_VAL(LINE_RESET)) u_line_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(sharedShutdownLineIn),
        .dout(lineSync)
    );

    // Fault sequencer: the hold counter counts down while a fault state is held
    always_comb begin
        state_d = state_q;
        holdCnt_d = (holdCnt_q != '0) ? holdCnt_q - HOLD_W'(1) : holdCnt_q;
        case (state_q)
            ST_RUN, ST_WAIT: begin
                if (overcurrentFault) begin
                    state_d = ST_OC;
                    holdCnt_d = OC_LOAD;
                end else if (uvSync) begin
                    state_d = ST_UV;
                    holdCnt_d = UV_LOAD;
                end else if (state_q == ST_WAIT && lineSync) begin
                    state_d = ST_RUN;
                end
            end
            ST_OC: begin
                // Hold runs from entry, so the pull-down stands for the longer of hold and event;
                // release also needs the line below the unlatch level
                if (!overcurrentFault && holdCnt_q == '0 && unlatchSync) begin
                    if (uvSync) begin
                        state_d = ST_UV;
                        holdCnt_d = UV_LOAD;
                    end else begin
                        state_d = ST_WAIT;
                    end
                end
            end
            ST_UV: begin
                if (overcurrentFault) begin
                    state_d = ST_OC;
                    holdCnt_d = OC_LOAD;
                end else if (!uvSync && holdCnt_q == '0) begin
                    state_d = ST_WAIT;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
        // A fault still seen wins over the clear, so the pull-down never drops under a fault
        if (faultClear && !overcurrentFault && !uvSync) begin
            state_d = ST_WAIT;
            holdCnt_d = '0;
        end
    end

    // Pull-down and gate registers follow the next state, so a fault acts on the very next edge
    always_comb begin
        pullOe_d = (state_d == ST_OC) || (state_d == ST_UV);
        // Gates run only in the run state with the line seen high
        if (state_d == ST_RUN && lineSync) begin
            highGate_d = highCmdSync;
            lowGate_d = lowCmdSync;
        end else begin
            highGate_d = '0;
            lowGate_d = '0;
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_WAIT;
            holdCnt_q <= '0;
            pullOe_q <= 1'h0;
            highGate_q <= '0;
            lowGate_q <= '0;
        end else begin
            state_q <= state_d;
            holdCnt_q <= holdCnt_d;
            pullOe_q <= pullOe_d;
            highGate_q <= highGate_d;
            lowGate_q <= lowGate_d;
        end
    end

    // Raw comparator gates the outputs directly; waiting for the synchroniser
    // would add four cycles, and the gate register a fifth, to the turn-off delay
    assign highSideGate = highGate_q & {PHASES{~currentSenseInput}};
    assign lowSideGateOutputs = lowGate_q & {PHASES{~currentSenseInput}};
    assign sharedShutdownLineOe = pullOe_q;
    assign sharedShutdownLineOut = PULL_LEVEL;
    assign faultActive = pullOe_q;

    // Helper: cycles spent in the current fault state, for the hold-time checks
    logic [HOLD_W-1:0] age_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            age_q <= '0;
        end else if (state_d != state_q) begin
            age_q <= '0;
        end else if (age_q != '1) begin
            age_q <= age_q + HOLD_W'(1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_fault_pull_on: assert property ((overcurrentFault || uvSync) |=> pullOe_q)
        else $error("pull-down not enabled after fault");
    a_fault_gates_off: assert property (pullOe_q |-> lowGate_q == '0 && highGate_q == '0)
        else $error("gates on while pull-down active");
    a_oc_hold_time: assert property (state_q == ST_OC && state_d != ST_OC && !faultClear
        && !overcurrentFault |-> age_q >= HOLD_W'(OC_CYCLES - 1))
        else $error("overcurrent hold released early");
    a_uv_hold_time: assert property (state_q == ST_UV && state_d == ST_WAIT && !faultClear
        |-> age_q >= HOLD_W'(UV_CYCLES - 1))
        else $error("undervoltage hold released early");
    a_oc_unlatch_gate: assert property (state_q == ST_OC && !faultClear && !unlatchSync
        |=> state_q == ST_OC)
        else $error("overcurrent released without unlatch level");
    a_uv_tracks_supply: assert property (state_q == ST_UV && uvSync && !overcurrentFault
        |=> state_q == ST_UV && pullOe_q)
        else $error("undervoltage state left while supply low");
    a_oc_tracks_event: assert property (state_q == ST_OC && overcurrentFault
        |=> state_q == ST_OC && pullOe_q)
        else $error("overcurrent state left while event lasts");
    a_line_low_gates: assert property (!lineSync |=> lowGate_q == '0 && highGate_q == '0)
        else $error("gates on while shutdown line low");
    a_resume_follows: assert property (state_q == ST_WAIT && lineSync && !overcurrentFault
        && !uvSync && !faultClear |=> state_q == ST_RUN && lowGate_q == $past(lowCmdSync))
        else $error("gates did not resume with line high");
    a_direct_off: assert property (currentSenseInput |-> lowSideGateOutputs == '0)
        else $error("direct comparator gate-off failed");
    a_clear_drops: assert property (faultClear && !overcurrentFault && !uvSync
        |=> !pullOe_q ##1 (!pullOe_q || overcurrentFault || uvSync || $past(overcurrentFault)
        || $past(uvSync)))
        else $error("clear did not release pull-down");

    c_oc_entry: cover property (state_q == ST_RUN ##1 state_q == ST_OC);
    c_uv_entry: cover property (state_q == ST_RUN ##1 state_q == ST_UV);
    c_resume: cover property (state_q == ST_WAIT ##1 state_q == ST_RUN);
    c_oc_to_uv: cover property (state_q == ST_OC ##1 state_q == ST_UV);
endmodule

/* File: fault_pkg.sv */
// Shared constants for the inverter fault and smart-shutdown logic
package fault_pkg;
    // System clock rate
    localparam int unsigned CLK_FREQ_MHZ = 25;
    // Number of phases driven
    localparam int unsigned PHASES = 3;
    // Hold times in their own unit, as printed
    localparam int unsigned OC_HOLD_NS = 20000;
    localparam int unsigned UV_HOLD_NS = 50000;
    // Least times round up to whole cycles
    localparam int unsigned OC_HOLD_CYC = (OC_HOLD_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int unsigned UV_HOLD_CYC = (UV_HOLD_NS * CLK_FREQ_MHZ + 999) / 1000;
    // Width of the hold counter
    localparam int unsigned HOLD_W = 16;
    // Reset value of the synchronised shutdown line (idle high through pull-up)
    localparam logic LINE_RESET = 1'h1;
    // Reset value of the other synchronised inputs
    localparam logic IN_RESET = 1'h0;
    // Level driven on the shutdown line when the pull-down is enabled
    localparam logic PULL_LEVEL = 1'h0;

    // Fault state machine, one-hot
    typedef enum logic [3:0] {
        ST_RUN  = 4'h1,
        ST_OC   = 4'h2,
        ST_UV   = 4'h4,
        ST_WAIT = 4'h8
    } fault_state_e;
endpackage

/* File: pin_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] out_d;

    // Only agreeing bits of stages two and three update; stage one feeds stage two alone
    always_comb begin
        out_d = out_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    // Flop chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            out_q <= RESET_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule

/* File: host_model.sv */
// Host-side model of the shared shutdown line: pull-up, host pull-down and slow RC discharge
`timescale 1ns/1ns
module host_model #(
    parameter int DISCHARGE = 12
) (
    input wire logic clk,
    input wire logic pullOe,
    input wire logic pullLevel,
    input wire logic hostPull,
    output logic lineLevel,
    output logic belowUnlatch
);
    int lowCount = 0;
    // Wire-AND of both open drains against the pull-up; released line goes high
    assign lineLevel = (pullOe ? pullLevel : 1'b1) & ~hostPull;
    // RC network: the line sinks below the unlatch level only some time after it falls
    always @(posedge clk) begin
        lowCount <= lineLevel ? 0 : lowCount + 1;
    end
    assign belowUnlatch = (lowCount >= DISCHARGE);
endmodule

/* File: inverter_fault_shutdown_logic_tb.sv */
// Self-checking testbench for the fault and smart-shutdown logic
`timescale 1ns/1ns
module inverter_fault_shutdown_logic_tb;
    import fault_pkg::*;
    // Short hold counts keep the run small; the slow discharge outlasts the overcurrent hold
    localparam int OC_N = 4;
    localparam int UV_N = 8;
    localparam int DIS_N = 12;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic faultClear = 1'b0;
    logic [PHASES-1:0] hiCmd = 3'h0;
    logic [PHASES-1:0] loCmd = 3'h0;
    logic trip = 1'b0;
    logic underVolt = 1'b0;
    logic hostPull = 1'b0;
    logic lineLevel;
    logic belowUnlatch;
    logic lineOut;
    logic lineOe;
    logic active;
    logic [PHASES-1:0] hiGate;
    logic [PHASES-1:0] loGate;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    inverter_fault_shutdown_logic #(.OC_CYCLES(OC_N), .UV_CYCLES(UV_N))
        inverter_fault_shutdown_logic_inst (
        .clk(clk), .rst_n(rst_n), .faultClear(faultClear),
        .highSideCommand(hiCmd), .lowSideCommand(loCmd),
        .currentSenseInput(trip), .undervoltageLockout(underVolt),
        .sharedShutdownLineIn(lineLevel), .unlatchQualifier(belowUnlatch),
        .sharedShutdownLineOut(lineOut), .sharedShutdownLineOe(lineOe),
        .highSideGate(hiGate), .lowSideGateOutputs(loGate), .faultActive(active));

    host_model #(.DISCHARGE(DIS_N)) host_model_inst (
        .clk(clk), .pullOe(lineOe), .pullLevel(lineOut), .hostPull(hostPull),
        .lineLevel(lineLevel), .belowUnlatch(belowUnlatch));

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(string what, logic [2:0] expv, logic [2:0] got);
        n_compared++;
        if (got !== expv) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, expv, got);
        end
    endtask

    // Set active-high commands, let the synchronisers settle, compare gates
    task automatic follow(logic [2:0] hi, logic [2:0] lo);
        @(negedge clk);
        hiCmd = hi;
        loCmd = lo;
        repeat (8) @(negedge clk);
        chk("high gates", hi, hiGate);
        chk("low gates", lo, loGate);
    endtask

    // One fault of len+1 cycles; the pull-down must stand between lo and lo+6 cycles
    task automatic fault_event(logic isOc, int len, int lo);
        int n;
        n = 0;
        @(negedge clk);
        if (isOc) trip = 1'b1;
        else underVolt = 1'b1;
        #1;
        if (isOc) chk("gates at trip", 3'h0, hiGate | loGate);
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk);
            // Five edges cover the synchroniser and the state register
            if (i == 5) begin
                chk("gates in fault", 3'h0, hiGate | loGate);
                chk("fault flag", 3'h1, {2'h0, active});
            end
            if (i == len) begin
                trip = 1'b0;
                underVolt = 1'b0;
            end
            if (lineOe === 1'b1) n++;
            if (i > len && n > 0 && lineOe === 1'b0) break;
        end
        chk("hold in range", 3'h1, {2'h0, n >= lo && n <= lo + 6});
        follow(3'h6, 3'h1);
    endtask

    // Overcurrent over an undervoltage: the pull-down must outlast the overcurrent hold
    task automatic both_faults();
        @(negedge clk);
        trip = 1'b1;
        underVolt = 1'b1;
        repeat (10) @(negedge clk);
        trip = 1'b0;
        repeat (20) @(negedge clk);
        chk("pull-down under undervoltage", 3'h1, {2'h0, lineOe});
        chk("gates under undervoltage", 3'h0, hiGate | loGate);
        underVolt = 1'b0;
        repeat (10) @(negedge clk);
        chk("pull-down after both faults", 3'h0, {2'h0, lineOe});
        follow(3'h4, 3'h2);
    endtask

    // Host holds the line low: no pull-down, gates off, then resume on release
    task automatic host_hold();
        @(negedge clk);
        hostPull = 1'b1;
        repeat (20) @(negedge clk);
        chk("gates while held", 3'h0, hiGate | loGate);
        chk("no pull-down", 3'h0, {2'h0, lineOe});
        hostPull = 1'b0;
        follow(3'h3, 3'h5);
    endtask

    // Clear in mid-hold drops the pull-down before the discharge unlatches it
    task automatic clear_mid();
        @(negedge clk);
        trip = 1'b1;
        repeat (2) @(negedge clk);
        trip = 1'b0;
        repeat (8) @(negedge clk);
        chk("pull-down before clear", 3'h1, {2'h0, lineOe});
        faultClear = 1'b1;
        @(negedge clk);
        faultClear = 1'b0;
        @(negedge clk);
        chk("pull-down after clear", 3'h0, {2'h0, lineOe});
        follow(3'h7, 3'h7);
    endtask

    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        follow(3'h5, 3'h3);
        follow(3'h2, 3'h4);
        fault_event(1'b1, 2, DIS_N);
        fault_event(1'b1, 40, 38);
        fault_event(1'b0, 2, UV_N);
        fault_event(1'b0, 40, 38);
        both_faults();
        host_hold();
        clear_mid();
        give_verdict();
    end
endmodule
